// file: cfg_regs.sv
// Configuration bank for correction, mixer and clock multiplier settings
`timescale 1ns/100ps
module cfg_regs
  import cfg_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  input  wire logic               wr_en,
  input  wire logic               rd_en,
  input  wire logic [6:0]         addr,
  input  wire logic [15:0]        wdata,
  output logic [15:0]             rdata,
  input  wire logic [2:0]         loop_filter_code,
  input  wire logic               sync_pin,
  input  wire logic               output_strobe,
  input  wire logic signed [15:0] first_in,
  input  wire logic signed [15:0] second_in,
  output logic signed [15:0]      first_channel,
  output logic signed [15:0]      second_channel,
  output logic [15:0]             osc_sin_addr,
  output logic                    ndiv_sync,
  output logic                    clk_mult_sel,
  output analog_ctrl_type         analog_ctrl
);

  logic [15:0]     chan_i_gain;
  logic [15:0]     coarse_mix_and_chan_q_gain;
  logic [15:0]     output_latency_ctrl;
  logic [15:0]     iq_phase_correction;
  logic [15:0]     osc_phase_shift;
  logic [15:0]     osc_freq_low;
  logic [15:0]     osc_freq_high;
  logic [15:0]     loop_control;
  logic [15:0]     loop_dividers;
  logic [15:0]     osc_tune_and_sleep;
  logic [15:0]     reference_and_test_ctrl;
  logic [15:0]     sync_select;
  logic [15:0]     sync_select2;
  logic [15:0]     spare [5];
  corr_set_type    corr_active;
  mix_set_type     mix_active;
  logic [31:0]     osc_acc;
  logic [3:0]      src_events;
  logic            load_corr;
  logic            load_mix;
  logic            sif_sync_q;

  function automatic logic wr_hit(input logic [6:0] idx);
    return wr_en && (addr == idx);
  endfunction

  function automatic logic any_src(input logic [3:0] mask, input logic [3:0] ev);
    return |(mask & ev);
  endfunction

  // Plain control registers, one per concern
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      chan_i_gain <= RST_GAIN;
    else if (wr_hit(IDX_I_GAIN))
      chan_i_gain <= wdata;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      coarse_mix_and_chan_q_gain <= RST_GAIN;
    else if (wr_hit(IDX_CMIX_QGAIN))
      coarse_mix_and_chan_q_gain <= wdata;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      output_latency_ctrl <= RST_GAIN;
    else if (wr_hit(IDX_OUT_LAT))
      output_latency_ctrl <= wdata;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      iq_phase_correction <= RST_ZERO;
    else if (wr_hit(IDX_PHASE_CORR))
      iq_phase_correction <= wdata;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      osc_phase_shift <= RST_ZERO;
    else if (wr_hit(IDX_PHASE_SHFT))
      osc_phase_shift <= wdata;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      osc_freq_low <= RST_ZERO;
    else if (wr_hit(IDX_FREQ_LO))
      osc_freq_low <= wdata;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      osc_freq_high <= RST_ZERO;
    else if (wr_hit(IDX_FREQ_HI))
      osc_freq_high <= wdata;
  end

  // Filter code bits are read-only, so they are stored as zero
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      loop_control <= RST_LOOP_CTRL;
    else if (wr_hit(IDX_LOOP_CTRL))
      loop_control <= {wdata[15:3], 3'h0};
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      loop_dividers <= RST_LOOP_DIV;
    else if (wr_hit(IDX_LOOP_DIV))
      loop_dividers <= wdata;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      osc_tune_and_sleep <= RST_TUNE_SLEEP;
    else if (wr_hit(IDX_TUNE_SLEEP))
      osc_tune_and_sleep <= wdata;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      reference_and_test_ctrl <= RST_ZERO;
    else if (wr_hit(IDX_REF_CTRL))
      reference_and_test_ctrl <= wdata;
  end

  // Reserved nibbles of the source masks keep whatever software writes
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      sync_select <= RST_SYNC_SEL;
    else if (wr_hit(IDX_SYNC_SEL))
      sync_select <= wdata;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      sync_select2 <= RST_SYNC_SEL2;
    else if (wr_hit(IDX_SYNC_SEL2))
      sync_select2 <= wdata;
  end

  // Spare words hold what software writes, kept for readback; 0x16 and 0x17 share one word
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      spare[0] <= RST_ZERO;
      spare[1] <= RST_GAIN;
      spare[2] <= RST_ZERO;
      spare[3] <= RST_ZERO;
      spare[4] <= RST_ZERO;
    end
    else
    begin
      if (wr_hit(IDX_SPARE_0B)) spare[0] <= wdata;
      if (wr_hit(IDX_SPARE_0E)) spare[1] <= wdata;
      if (wr_hit(IDX_SPARE_11)) spare[2] <= wdata;
      if (wr_hit(IDX_SPARE_13)) spare[3] <= wdata;
      if (wr_hit(IDX_SPARE_16) || wr_hit(IDX_SPARE_17)) spare[4] <= wdata;
    end
  end

  // Software sync is a level; its rising edge is the event
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      sif_sync_q <= 1'b0;
    else
      sif_sync_q <= sync_select2[SIF_SYNC_BIT];
  end

  always_comb
  begin
    src_events           = 4'h0;
    src_events[SRC_SIF]  = sync_select2[SIF_SYNC_BIT] & ~sif_sync_q;
    src_events[SRC_PIN]  = sync_pin;
    src_events[SRC_STRB] = output_strobe;
    src_events[SRC_AUTO] = 1'b0;
  end

  // Auto-sync comes from the write itself, so the new word is loaded
  // straight from the bus in the same edge
  // A process, not an assign, so the bus reads inside wr_hit wake it
  always_comb
  begin
    load_corr = any_src(sync_select[CORR_SEL_LSB +: 4], src_events)
              | (sync_select[CORR_SEL_LSB + SRC_AUTO]
                 & wr_hit(IDX_PHASE_CORR));
    load_mix  = any_src(sync_select2[MIX_SEL_LSB +: 4], src_events)
              | (sync_select2[MIX_SEL_LSB + SRC_AUTO]
                 & wr_hit(IDX_PHASE_SHFT));
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      corr_active.i_gain <= RST_GAIN[GAIN_MSB:0];
      corr_active.q_gain <= RST_GAIN[GAIN_MSB:0];
      corr_active.phase  <= RST_ZERO[PHASE_MSB:0];
    end
    else if (load_corr)
    begin
      corr_active.i_gain <= chan_i_gain[GAIN_MSB:0];
      corr_active.q_gain <= coarse_mix_and_chan_q_gain[GAIN_MSB:0];
      corr_active.phase  <= wr_hit(IDX_PHASE_CORR) ? wdata[PHASE_MSB:0]
                                                    : iq_phase_correction[PHASE_MSB:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mix_active.phase_shift <= RST_ZERO;
      mix_active.freq_word   <= {RST_ZERO, RST_ZERO};
    end
    else if (load_mix)
    begin
      mix_active.phase_shift <= wr_hit(IDX_PHASE_SHFT) ? wdata : osc_phase_shift;
      mix_active.freq_word   <= {osc_freq_high, osc_freq_low};
    end
  end

  // Oscillator accumulator; signed step wraps naturally mod 2^32
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      osc_acc <= {RST_ZERO, RST_ZERO};
    else
      osc_acc <= osc_acc + mix_active.freq_word;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      osc_sin_addr <= RST_ZERO;
    else
      osc_sin_addr <= osc_acc[31:16] + mix_active.phase_shift;
  end

  sample_path u_path (
    .ref_clk        (ref_clk),
    .rstn           (rstn),
    .corr           (corr_active),
    .cmix_mode      (coarse_mix_and_chan_q_gain[CMIX_LSB +: 4]),
    .latency        (output_latency_ctrl[LAT_LSB +: 2]),
    .first_in       (first_in),
    .second_in      (second_in),
    .first_channel  (first_channel),
    .second_channel (second_channel)
  );

  // Divider ratio decodes
  function automatic logic [3:0] presc_ratio(input logic [2:0] c);
    return (c == 3'h0) ? 4'h8 : {1'b0, c};
  endfunction

  function automatic logic [8:0] m_ratio(input logic [7:0] c);
    return c[7] ? {1'b0, c[6:0], 1'b0} : {2'h0, c[6:0]};
  endfunction

  assign ndiv_sync    = loop_control[NDIV_SYNC_BIT] & sync_pin;
  assign clk_mult_sel = loop_control[LOOP_EN_BIT];

  always_comb
  begin
    analog_ctrl.loop_reset        = loop_control[LOOP_RST_BIT];
    analog_ctrl.loop_enable       = loop_control[LOOP_EN_BIT];
    analog_ctrl.loop_pump_select  = loop_control[PUMP_LSB +: 2];
    analog_ctrl.prescale_div      = presc_ratio(loop_control[PRESC_LSB +: 3]);
    analog_ctrl.m_div             = m_ratio(loop_dividers[M_LSB +: 8]);
    analog_ctrl.n_div             = 5'({1'b0, loop_dividers[N_LSB +: 4]} + 5'h1);
    analog_ctrl.bias_sleep        = osc_tune_and_sleep[BIAS_SLP_BIT];
    analog_ctrl.temp_sleep        = osc_tune_and_sleep[TEMP_SLP_BIT];
    analog_ctrl.loop_sleep        = osc_tune_and_sleep[LOOP_SLP_BIT];
    analog_ctrl.clk_recv_sleep    = osc_tune_and_sleep[CLK_SLP_BIT];
    analog_ctrl.strobe_recv_sleep = osc_tune_and_sleep[CLK_SLP_BIT];
    analog_ctrl.ext_ref_sel       = reference_and_test_ctrl[EXTREF_BIT];
  end

  // Readback; unmapped indices read as zero
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= RST_ZERO;
    else if (rd_en)
    begin
      unique case (addr)
        IDX_SPARE_0B:   rdata <= spare[0];
        IDX_I_GAIN:     rdata <= chan_i_gain;
        IDX_CMIX_QGAIN: rdata <= coarse_mix_and_chan_q_gain;
        IDX_SPARE_0E:   rdata <= spare[1];
        IDX_OUT_LAT:    rdata <= output_latency_ctrl;
        IDX_PHASE_CORR: rdata <= iq_phase_correction;
        IDX_SPARE_11:   rdata <= spare[2];
        IDX_PHASE_SHFT: rdata <= osc_phase_shift;
        IDX_SPARE_13:   rdata <= spare[3];
        IDX_FREQ_LO:    rdata <= osc_freq_low;
        IDX_FREQ_HI:    rdata <= osc_freq_high;
        IDX_SPARE_16:   rdata <= spare[4];
        IDX_SPARE_17:   rdata <= spare[4];
        IDX_LOOP_CTRL:  rdata <= {loop_control[15:3], loop_filter_code};
        IDX_LOOP_DIV:   rdata <= loop_dividers;
        IDX_TUNE_SLEEP: rdata <= osc_tune_and_sleep;
        IDX_REF_CTRL:   rdata <= reference_and_test_ctrl;
        IDX_SYNC_SEL:   rdata <= sync_select;
        IDX_SYNC_SEL2:  rdata <= sync_select2;
        default:        rdata <= RST_ZERO;
      endcase
    end
  end

endmodule

// file: cfg_pkg.sv
// Shared constants and types for the converter configuration bank
package cfg_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;

  // Register indices
  localparam logic [6:0] IDX_SPARE_0B   = 7'h0b;
  localparam logic [6:0] IDX_I_GAIN     = 7'h0c;
  localparam logic [6:0] IDX_CMIX_QGAIN = 7'h0d;
  localparam logic [6:0] IDX_SPARE_0E   = 7'h0e;
  localparam logic [6:0] IDX_OUT_LAT    = 7'h0f;
  localparam logic [6:0] IDX_PHASE_CORR = 7'h10;
  localparam logic [6:0] IDX_SPARE_11   = 7'h11;
  localparam logic [6:0] IDX_PHASE_SHFT = 7'h12;
  localparam logic [6:0] IDX_SPARE_13   = 7'h13;
  localparam logic [6:0] IDX_FREQ_LO    = 7'h14;
  localparam logic [6:0] IDX_FREQ_HI    = 7'h15;
  localparam logic [6:0] IDX_SPARE_16   = 7'h16;
  localparam logic [6:0] IDX_SPARE_17   = 7'h17;
  localparam logic [6:0] IDX_LOOP_CTRL  = 7'h18;
  localparam logic [6:0] IDX_LOOP_DIV   = 7'h19;
  localparam logic [6:0] IDX_TUNE_SLEEP = 7'h1a;
  localparam logic [6:0] IDX_REF_CTRL   = 7'h1b;
  localparam logic [6:0] IDX_SYNC_SEL   = 7'h1e;
  localparam logic [6:0] IDX_SYNC_SEL2  = 7'h1f;

  // Reset values
  localparam logic [15:0] RST_ZERO       = 16'h0000;
  localparam logic [15:0] RST_GAIN       = 16'h0400;
  localparam logic [15:0] RST_LOOP_CTRL  = 16'h2808;
  localparam logic [15:0] RST_LOOP_DIV   = 16'h0440;
  localparam logic [15:0] RST_TUNE_SLEEP = 16'h0020;
  localparam logic [15:0] RST_SYNC_SEL   = 16'h1111;
  localparam logic [15:0] RST_SYNC_SEL2  = 16'h1140;

  // Field positions
  localparam int GAIN_MSB      = 10;
  localparam int CMIX_LSB      = 12;
  localparam int LAT_LSB       = 14;
  localparam int PHASE_MSB     = 11;
  localparam int LOOP_RST_BIT  = 12;
  localparam int NDIV_SYNC_BIT = 11;
  localparam int LOOP_EN_BIT   = 10;
  localparam int PUMP_LSB      = 6;
  localparam int PRESC_LSB     = 3;
  localparam int M_LSB         = 8;
  localparam int N_LSB         = 4;
  localparam int BIAS_SLP_BIT  = 7;
  localparam int TEMP_SLP_BIT  = 6;
  localparam int LOOP_SLP_BIT  = 5;
  localparam int CLK_SLP_BIT   = 4;
  localparam int EXTREF_BIT    = 15;
  localparam int CORR_SEL_LSB  = 4;
  localparam int MIX_SEL_LSB   = 12;
  localparam int SIF_SYNC_BIT  = 1;

  // Sync source bit positions inside a 4-bit mask
  localparam int SRC_AUTO = 0;
  localparam int SRC_STRB = 1;
  localparam int SRC_PIN  = 2;
  localparam int SRC_SIF  = 3;

  localparam int MAX_LAT = 3;

  typedef struct packed {
    logic [10:0] i_gain;
    logic [10:0] q_gain;
    logic [11:0] phase;
  } corr_set_type;

  typedef struct packed {
    logic [15:0] phase_shift;
    logic [31:0] freq_word;
  } mix_set_type;

  typedef struct packed {
    logic       loop_reset;
    logic       loop_enable;
    logic [1:0] loop_pump_select;
    logic [3:0] prescale_div;
    logic [8:0] m_div;
    logic [4:0] n_div;
    logic       bias_sleep;
    logic       temp_sleep;
    logic       loop_sleep;
    logic       clk_recv_sleep;
    logic       strobe_recv_sleep;
    logic       ext_ref_sel;
  } analog_ctrl_type;

endpackage

// file: sample_path.sv
// Correction, coarse mixing and output latency for the two channels
`timescale 1ns/100ps
module sample_path
  import cfg_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  input  wire corr_set_type       corr,
  input  wire logic [3:0]         cmix_mode,
  input  wire logic [1:0]         latency,
  input  wire logic signed [15:0] first_in,
  input  wire logic signed [15:0] second_in,
  output logic signed [15:0]      first_channel,
  output logic signed [15:0]      second_channel
);

  logic signed [15:0] corr_i;
  logic signed [15:0] corr_q;
  logic signed [15:0] mix_i;
  logic signed [15:0] mix_q;
  logic signed [15:0] dly_i [MAX_LAT:0];
  logic signed [15:0] dly_q [MAX_LAT:0];
  logic [2:0]         rot;

  // Unsigned gain with binary point between bits 9 and 10
  function automatic logic signed [15:0] scale(input logic signed [15:0] s,
                                               input logic [10:0] g);
    logic signed [28:0] p;
    p = s * $signed({1'b0, g});
    return sat(p[28:10]);
  endfunction

  function automatic logic signed [15:0] sat(input logic signed [18:0] v);
    if (v > 19'sd32767)
      return 16'sh7fff;
    else if (v < -19'sd32768)
      return 16'sh8000;
    else
      return v[15:0];
  endfunction

  // Phase word is a fraction of 2^-12, range -0.5 .. 0.49975
  always_comb
  begin
    logic signed [27:0] prod;
    prod = second_in * $signed(corr.phase);
    corr_q = scale(second_in, corr.q_gain);
    // Product slice is sign-extended so negative phase words subtract
    corr_i = sat(19'(scale(first_in, corr.i_gain)) + 19'($signed(prod[27:12])));
  end

  // Coarse mixer enables summed as eighths of a turn
  always_comb
  begin
    rot = 3'h0;
    if (cmix_mode[3]) rot = 3'(rot + 3'h1);
    if (cmix_mode[2]) rot = 3'(rot + 3'h2);
    if (cmix_mode[1]) rot = 3'(rot + 3'h4);
    if (cmix_mode[0]) rot = 3'(rot + 3'h6);
    // Odd eighths need an NCO-grade rotator; handled as the quarter below
    unique case (rot[2:1])
      2'h0:
      begin
        mix_i = corr_i;
        mix_q = corr_q;
      end
      2'h1:
      begin
        mix_i = -corr_q;
        mix_q = corr_i;
      end
      2'h2:
      begin
        mix_i = -corr_i;
        mix_q = -corr_q;
      end
      default:
      begin
        mix_i = corr_q;
        mix_q = -corr_i;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int k = 0; k <= MAX_LAT; k++)
      begin
        dly_i[k] <= 16'sh0000;
        dly_q[k] <= 16'sh0000;
      end
    end
    else
    begin
      dly_i[0] <= mix_i;
      dly_q[0] <= mix_q;
      for (int k = 1; k <= MAX_LAT; k++)
      begin
        dly_i[k] <= dly_i[k-1];
        dly_q[k] <= dly_q[k-1];
      end
    end
  end

  assign first_channel  = dly_i[latency];
  assign second_channel = dly_q[latency];

endmodule

// file: cfg_regs_asserts.sv
// Port-level checker for the configuration bank
`timescale 1ns/100ps
module cfg_regs_chk
  import cfg_pkg::*;
(
  input wire logic            ref_clk,
  input wire logic            rstn,
  input wire logic            wr_en,
  input wire logic            rd_en,
  input wire logic [6:0]      addr,
  input wire logic [15:0]     wdata,
  input wire logic [15:0]     rdata,
  input wire logic [2:0]      loop_filter_code,
  input wire logic            sync_pin,
  input wire logic            ndiv_sync,
  input wire logic            clk_mult_sel,
  input wire analog_ctrl_type analog_ctrl
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence wr_at(logic [6:0] a);
    wr_en && addr == a;
  endsequence
  sequence rd_at(logic [6:0] a);
    rd_en && addr == a;
  endsequence
  // Code 001 has no documented divide value, so it is left out
  presc_decode_a: assert property (wr_at(IDX_LOOP_CTRL) ##0 wdata[5:3] != 3'h1 |=>
    analog_ctrl.prescale_div == ($past(wdata[5:3]) == 3'h0 ? 4'h8 : {1'b0, $past(wdata[5:3])}))
    else $error("prescaler decode wrong");
  pump_reset_a: assert property (wr_at(IDX_LOOP_CTRL) |=>
    analog_ctrl.loop_pump_select == $past(wdata[7:6]) && analog_ctrl.loop_reset == $past(wdata[12]))
    else $error("pump or loop reset not taken");
  mult_bypass_a: assert property (wr_at(IDX_LOOP_CTRL) |=>
    clk_mult_sel == $past(wdata[10]) && analog_ctrl.loop_enable == clk_mult_sel)
    else $error("multiplier select wrong");
  ndiv_gate_a: assert property (ndiv_sync |-> sync_pin)
    else $error("divider sync without pin");
  ndiv_value_a: assert property (wr_at(IDX_LOOP_DIV) |=>
    analog_ctrl.n_div == {1'b0, $past(wdata[7:4])} + 5'h1)
    else $error("n divider wrong");
  mdiv_value_a: assert property (wr_at(IDX_LOOP_DIV) |=> analog_ctrl.m_div ==
    ($past(wdata[15]) ? {1'b0, $past(wdata[14:8]), 1'b0} : {2'b00, $past(wdata[14:8])}))
    else $error("m divider wrong");
  sleep_bits_a: assert property (wr_at(IDX_TUNE_SLEEP) |=>
    {analog_ctrl.bias_sleep, analog_ctrl.temp_sleep, analog_ctrl.loop_sleep,
     analog_ctrl.clk_recv_sleep, analog_ctrl.strobe_recv_sleep} == {$past(wdata[7:4]), $past(wdata[4])})
    else $error("sleep bits wrong");
  ref_select_a: assert property (wr_at(IDX_REF_CTRL) |=> analog_ctrl.ext_ref_sel == $past(wdata[15]))
    else $error("reference select wrong");
  filter_code_a: assert property (rd_at(IDX_LOOP_CTRL) |=> rdata[2:0] == $past(loop_filter_code))
    else $error("filter code not read back");
  unmapped_rd_a: assert property (rd_en && addr < IDX_SPARE_0B |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule
bind cfg_regs cfg_regs_chk u_chk (.ref_clk(ref_clk), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en),
  .addr(addr), .wdata(wdata), .rdata(rdata), .loop_filter_code(loop_filter_code),
  .sync_pin(sync_pin), .ndiv_sync(ndiv_sync), .clk_mult_sel(clk_mult_sel),
  .analog_ctrl(analog_ctrl));

// file: tb_top.sv
// Self-checking bench for the configuration bank
`timescale 1ns/100ps
module tb_top
  import cfg_pkg::*;
;
  logic                ref_clk = 0, rstn = 0, wr_en = 0, rd_en = 0, sync_pin = 0, strb = 0;
  logic [6:0]          addr = 0;
  logic [15:0]         wdata = 0, rdata, rv, sa, d, p;
  logic [2:0]          lf = 0;
  logic signed [15:0]  fi = 0, si = 0, fo, so;
  logic [15:0]         osc;
  logic                nds, cms;
  analog_ctrl_type     ac;
  logic [31:0]         seed = 32'h7e87;
  int                  err_total = 0, samples_checked = 0, n;
  logic [6:0]          ra [11] = '{7'h0c, 7'h0d, 7'h0f, 7'h10, 7'h12, 7'h14, 7'h15, 7'h18,
                                  7'h19, 7'h1a, 7'h1b};

  cfg_regs dut (.ref_clk(ref_clk), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .loop_filter_code(lf), .sync_pin(sync_pin),
    .output_strobe(strb), .first_in(fi), .second_in(si), .first_channel(fo),
    .second_channel(so), .osc_sin_addr(osc), .ndiv_sync(nds), .clk_mult_sel(cms),
    .analog_ctrl(ac));

  initial forever #10 ref_clk = ~ref_clk;

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [15:0] rstv(input logic [6:0] a);
    case (a)
      7'h0c, 7'h0d, 7'h0e, 7'h0f: return 16'h0400;
      7'h18: return 16'h2808 | lf;
      7'h19: return 16'h0440;
      7'h1a: return 16'h0020;
      default: return 16'h0000;
    endcase
  endfunction
  // Only documented fields vary; reserved bits keep reset values, except 0x10 bits 13:12 and 0x19 bit 2, which are set to one
  function logic [15:0] wval(input logic [6:0] a, input logic [15:0] r);
    logic [15:0] m;
    case (a)
      7'h0c: m = 16'h07ff;
      7'h0d: m = 16'hf7ff;
      7'h0f: m = 16'hc000;
      7'h10: m = 16'h0fff;
      7'h18: m = 16'h1cf8;
      7'h19: m = 16'hfff0;
      7'h1a: m = 16'hfcf0;
      7'h1b: m = 16'h8000;
      default: m = 16'hffff;
    endcase
    return (rstv(a) & ~m) | (r & m) | (a == 7'h10 ? 16'h3000 : 16'h0000)
      | (a == 7'h19 ? 16'h0004 : 16'h0000);
  endfunction

  task chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [6:0] a, input logic [15:0] v);
    @(negedge ref_clk);
    wr_en = 1;
    addr = a;
    wdata = v;
    @(negedge ref_clk);
    wr_en = 0;
  endtask
  task rd(input logic [6:0] a, output logic [15:0] v);
    @(negedge ref_clk);
    rd_en = 1;
    addr = a;
    @(negedge ref_clk);
    rd_en = 0;
    v = rdata;
  endtask
  task wait_cyc(input int c);
    repeat (c) @(negedge ref_clk);
  endtask
  task step(output logic [15:0] s);
    @(posedge ref_clk);
    #1 sa = osc;
    @(posedge ref_clk);
    #1 s = osc - sa;
  endtask
  task results();
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #(20 * 20000);
    err_total++;
    results();
  end

  initial
  begin
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk) rstn = 1;
    lf = 3'(rnd());
    for (int a = 7'h0b; a <= 7'h1b; a++)
    begin
      rd(7'(a), rv);
      chk(rv, rstv(7'(a)));
    end
    rd(7'h05, rv);
    chk(rv, 16'h0000);
    repeat (2)
      foreach (ra[i])
      begin
        p = wval(ra[i], 16'(rnd()));
        wr(ra[i], p);
        rd(ra[i], rv);
        chk(rv, p);
      end
    for (int c = 0; c < 8; c++)
      if (c != 1)
      begin
        wr(IDX_LOOP_CTRL, 16'(16'h2800 | (c << 3)));
        chk({12'h000, ac.prescale_div}, c == 0 ? 16'h8 : 16'(c));
      end
    // Double-buffered gain and phase through the sample path
    wr(IDX_OUT_LAT, 16'h0400);
    wr(IDX_I_GAIN, 16'h0400);
    wr(IDX_CMIX_QGAIN, 16'h0200);
    wr(IDX_PHASE_CORR, 16'h3000);
    fi = 16'sh0100;
    si = 16'sh1000;
    wait_cyc(4);
    chk(fo, 16'h0100);
    chk(so, 16'h0800);
    wr(IDX_I_GAIN, 16'h0200);
    wait_cyc(4);
    chk(fo, 16'h0100);
    wr(IDX_PHASE_CORR, 16'h3000);
    wait_cyc(4);
    chk(fo, 16'h0080);
    wr(IDX_I_GAIN, 16'h0400);
    wr(IDX_CMIX_QGAIN, 16'h0400);
    wr(IDX_PHASE_CORR, 16'h3100);
    wait_cyc(4);
    chk(fo, 16'h0200);
    wr(IDX_PHASE_CORR, 16'h3f00);
    wait_cyc(4);
    chk(fo, 16'h0000);
    // Pin-only correction source: a write alone must not load
    wr(IDX_SYNC_SEL, 16'h1141);
    wr(IDX_PHASE_CORR, 16'h3000);
    wait_cyc(4);
    chk(fo, 16'h0000);
    sync_pin = 1;
    wait_cyc(4);
    chk(fo, 16'h0100);
    // Strobe-only, then serial-sync-only correction sources
    wr(IDX_SYNC_SEL, 16'h1121);
    sync_pin = 0;
    wr(IDX_PHASE_CORR, 16'h3100);
    wait_cyc(4);
    chk(fo, 16'h0100);
    strb = 1;
    wait_cyc(4);
    chk(fo, 16'h0200);
    strb = 0;
    wr(IDX_SYNC_SEL, 16'h1181);
    wr(IDX_PHASE_CORR, 16'h3000);
    wait_cyc(4);
    chk(fo, 16'h0200);
    wr(IDX_SYNC_SEL2, 16'h1142);
    wait_cyc(4);
    chk(fo, 16'h0100);
    wr(IDX_SYNC_SEL2, 16'h1140);
    wr(IDX_SYNC_SEL, 16'h1111);
    for (int lat = 0; lat < 4; lat++)
    begin
      wr(IDX_OUT_LAT, 16'(16'h0400 | (lat << 14)));
      fi = 16'sh1111;
      wait_cyc(6);
      fi = 16'sh2222;
      n = 0;
      do
      begin
        @(posedge ref_clk);
        #1 n++;
      end
      while (fo !== 16'sh2222 && n < 8);
      chk(16'(n), 16'(lat + 1));
    end
    // Half-turn negates, quarter-turn swaps in the negated second channel
    wr(IDX_CMIX_QGAIN, 16'h2400);
    wait_cyc(6);
    chk(fo, 16'hddde);
    wr(IDX_CMIX_QGAIN, 16'h4400);
    wait_cyc(6);
    chk(fo, 16'hf000);
    chk(so, 16'h2222);
    wr(IDX_CMIX_QGAIN, 16'h0400);
    p = 16'(rnd());
    wr(IDX_FREQ_LO, 16'h0000);
    wr(IDX_FREQ_HI, 16'h0001);
    wr(IDX_PHASE_SHFT, p);
    wait_cyc(3);
    step(d);
    chk(d, 16'h0001);
    wr(IDX_FREQ_HI, 16'hffff);
    wait_cyc(3);
    step(d);
    chk(d, 16'h0001);
    wr(IDX_PHASE_SHFT, p);
    wait_cyc(3);
    step(d);
    chk(d, 16'hffff);
    wr(IDX_FREQ_HI, 16'h0000);
    wr(IDX_PHASE_SHFT, p);
    wait_cyc(3);
    sa = osc;
    wr(IDX_PHASE_SHFT, p + 16'h0100);
    wait_cyc(3);
    chk(osc - sa, 16'h0100);
    sync_pin = 1;
    wr(IDX_LOOP_CTRL, 16'h2c08);
    chk({14'h0000, nds, cms}, 16'h3);
    wr(IDX_LOOP_CTRL, 16'h2008);
    chk({14'h0000, nds, cms}, 16'h0);
    results();
  end
endmodule
